// File: hsps_cfg.svh
`ifndef HSPS_CFG_SVH
`define HSPS_CFG_SVH

// Clock rate
`define HSPS_CLK_KHZ        100000
`define HSPS_CLK_MHZ        100

// Documented times, in their own unit
`define HSPS_T_QUAL_MS      16
`define HSPS_T_COOL_MS      16
`define HSPS_T_CB_MS        2
`define HSPS_T_VDD_FAST_US  5
`define HSPS_T_RAIL_FAST_US 1

// Cycle counts derived from the times
`define HSPS_QUAL_CYC  (`HSPS_T_QUAL_MS * `HSPS_CLK_KHZ)
`define HSPS_COOL_CYC  (`HSPS_T_COOL_MS * `HSPS_CLK_KHZ)
`define HSPS_CB_CYC    (`HSPS_T_CB_MS * `HSPS_CLK_KHZ)
`define HSPS_VDD_CYC   (`HSPS_T_VDD_FAST_US * `HSPS_CLK_MHZ)
`define HSPS_RAIL_CYC  (`HSPS_T_RAIL_FAST_US * `HSPS_CLK_MHZ)

// Counter width
`define HSPS_CW        24

// Register byte offsets
`define HSPS_OFS_CTRL    12'h000
`define HSPS_OFS_STATUS  12'h004
`define HSPS_OFS_QUAL_TC 12'h008
`define HSPS_OFS_CB_TC   12'h00C
`define HSPS_OFS_COOL_TC 12'h010

// Field positions and reset values
`define HSPS_CTRL_SW_OFF 0
`define HSPS_CTRL_RST    32'h0000_0000

// Bus responses
`define HSPS_RESP_OKAY   2'h0
`define HSPS_RESP_SLVERR 2'h2

`endif

// File: hsps_pkg.sv
package hsps_pkg;

  // Sequencer states
  typedef enum logic [2:0] {
    HSPS_QUAL  = 3'b000,
    HSPS_ON    = 3'b001,
    HSPS_CB    = 3'b010,
    HSPS_DISCH = 3'b011,
    HSPS_COOL  = 3'b100,
    HSPS_LATCH = 3'b101
  } hsps_state_t;

  // Comparator decisions, already synchronous to clk_i
  typedef struct packed {
    logic fb_pg_lo;      // Feedback below 1.21V
    logic fb_pg_hi;      // Feedback above 1.23V
    logic gate_ovd;      // Gate to output above 4.2V
    logic fb_fold;       // Feedback below 0.6V
    logic supply_high;   // Overvoltage input above 1.235V
    logic uv_low;        // Undervoltage input below 1.15V
    logic uv_reset;      // Undervoltage input below 0.62V
    logic overcurrent;   // Current limit engaged
    logic timer_high;    // Timer node above 1.235V
    logic timer_low;     // Timer node below 0.21V
    logic timer_tied;    // Timer pin tied to the internal rail
    logic main_lockout;  // Main supply below 2.73V
    logic vdd_fast;      // Main supply below 2.65V
    logic rail_fast;     // Internal rail below 2.5V
    logic temp_hi;       // Die above 145C
    logic temp_lo;       // Die at or below 125C
  } hsps_cmp_t;

  // Gate drive selection
  typedef struct packed {
    logic charge;
    logic pd_norm;
    logic pd_fast;
  } hsps_gate_t;

endpackage : hsps_pkg

// File: hsps_timer.sv
`timescale 1ns/1ps
`default_nettype none
`include "hsps_cfg.svh"

// Delay counter: counts while run_i, clears when run_i drops
module hsps_timer (
  input  wire logic                 clk_i,
  input  wire logic                 rstn_i,
  input  wire logic                 run_i,
  input  wire logic [`HSPS_CW-1:0]  tc_i,
  output logic                      done_o
);
  logic [`HSPS_CW-1:0] cnt_ff;

  // Saturates at the terminal count so done stays high
  always_ff @(posedge clk_i)
  begin
    if (!rstn_i || !run_i)
      cnt_ff <= '0;
    else if (cnt_ff < tc_i)
      cnt_ff <= cnt_ff + `HSPS_CW'(1);
  end

  assign done_o = run_i && (cnt_ff >= tc_i);
endmodule : hsps_timer

`default_nettype wire

// File: hsps_gate_sel.sv
`timescale 1ns/1ps
`default_nettype none

// Registered gate drive priority
module hsps_gate_sel (
  input  wire logic               clk_i,
  input  wire logic               rstn_i,
  input  wire logic               want_fast_i,
  input  wire logic               want_norm_i,
  input  wire logic               want_charge_i,
  output hsps_pkg::hsps_gate_t    gate_o
);
  import hsps_pkg::*;

  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
      gate_o <= '{charge: 1'b0, pd_norm: 1'b1, pd_fast: 1'b0};
    else
    begin
      gate_o.pd_fast <= want_fast_i;
      gate_o.pd_norm <= want_norm_i && !want_fast_i;
      gate_o.charge  <= want_charge_i && !want_fast_i && !want_norm_i;
    end
  end
endmodule : hsps_gate_sel

`default_nettype wire

// File: hsps_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "hsps_cfg.svh"

module hsps_top #(
  parameter logic [`HSPS_CW-1:0] QUAL_CYC = `HSPS_CW'(`HSPS_QUAL_CYC),
  parameter logic [`HSPS_CW-1:0] COOL_CYC = `HSPS_CW'(`HSPS_COOL_CYC),
  parameter logic [`HSPS_CW-1:0] CB_CYC   = `HSPS_CW'(`HSPS_CB_CYC)
) (
  input  wire logic                clk_i,
  input  wire logic                rstn_i,
  input  wire hsps_pkg::hsps_cmp_t cmp_i,
  output hsps_pkg::hsps_gate_t     gate_o,
  output logic                     foldback_o,
  output logic                     timer_up_o,
  output logic                     timer_dn_o,
  input  wire logic                power_good_i,
  output logic                     power_good_o,
  output logic                     power_good_oe_o,
  input  wire logic                fault_i,
  output logic                     fault_o,
  output logic                     fault_oe_o,
  input  wire logic                s_axi_awvalid,
  output logic                     s_axi_awready,
  input  wire logic [11:0]         s_axi_awaddr,
  input  wire logic                s_axi_wvalid,
  output logic                     s_axi_wready,
  input  wire logic [31:0]         s_axi_wdata,
  input  wire logic [3:0]          s_axi_wstrb,
  output logic                     s_axi_bvalid,
  input  wire logic                s_axi_bready,
  output logic [1:0]               s_axi_bresp,
  input  wire logic                s_axi_arvalid,
  output logic                     s_axi_arready,
  input  wire logic [11:0]         s_axi_araddr,
  output logic                     s_axi_rvalid,
  input  wire logic                s_axi_rready,
  output logic [31:0]              s_axi_rdata,
  output logic [1:0]               s_axi_rresp
);
  import hsps_pkg::*;

  hsps_state_t         state_ff;
  logic                fault_ff;
  logic                pg_ok_ff;
  logic                therm_ff;
  logic                fold_ff;
  logic [31:0]         ctrl_ff;
  logic [`HSPS_CW-1:0] qual_tc_ff;
  logic [`HSPS_CW-1:0] cb_tc_ff;
  logic [`HSPS_CW-1:0] cool_tc_ff;
  logic                aw_hold_ff;
  logic                w_hold_ff;
  logic [11:0]         awaddr_ff;
  logic [31:0]         wdata_ff;
  logic [3:0]          wstrb_ff;
  logic                supplies_ok;
  logic                fast_off;
  logic                qual_done;
  logic                cool_done;
  logic                cb_done;
  logic                vdd_done;
  logic                rail_done;
  logic                cb_trip;
  logic                want_fast;
  logic                want_norm;
  logic                want_charge;
  logic                wr_go;

  // Merge write strobes into an old register value
  function automatic logic [31:0] merge_bytes(input logic [31:0] old_v,
                                              input logic [31:0] new_v,
                                              input logic [3:0]  strb);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++)
      if (strb[i])
        res[8*i +: 8] = new_v[8*i +: 8];
    return res;
  endfunction : merge_bytes

  // Merge into a delay count; bit 0 is forced so a zero count becomes one
  function automatic logic [`HSPS_CW-1:0] merge_tc(
      input logic [`HSPS_CW-1:0] old_v,
      input logic [31:0]         new_v,
      input logic [3:0]          strb);
    logic [31:0] res;
    res = merge_bytes({8'h00, old_v}, new_v, strb);
    return res[`HSPS_CW-1:0] | `HSPS_CW'(1);
  endfunction : merge_tc

  // Map a byte offset onto a known register
  function automatic logic is_mapped(input logic [11:0] addr);
    return addr == `HSPS_OFS_CTRL    || addr == `HSPS_OFS_STATUS ||
           addr == `HSPS_OFS_QUAL_TC || addr == `HSPS_OFS_CB_TC  ||
           addr == `HSPS_OFS_COOL_TC;
  endfunction : is_mapped

  // delay timers with programmable terminal counts
  hsps_timer u_qual (
    .clk_i  (clk_i),
    .rstn_i (rstn_i),
    .run_i  (state_ff == HSPS_QUAL && supplies_ok),
    .tc_i   (qual_tc_ff),
    .done_o (qual_done)
  );

  hsps_timer u_cool (
    .clk_i  (clk_i),
    .rstn_i (rstn_i),
    .run_i  (state_ff == HSPS_COOL),
    .tc_i   (cool_tc_ff),
    .done_o (cool_done)
  );

  // programmable internal breaker delay when the timer pin is tied high
  hsps_timer u_cb (
    .clk_i  (clk_i),
    .rstn_i (rstn_i),
    .run_i  (state_ff == HSPS_CB && cmp_i.timer_tied),
    .tc_i   (cb_tc_ff),
    .done_o (cb_done)
  );

  hsps_timer u_vdd (
    .clk_i  (clk_i),
    .rstn_i (rstn_i),
    .run_i  (cmp_i.vdd_fast),
    .tc_i   (`HSPS_CW'(`HSPS_VDD_CYC)),
    .done_o (vdd_done)
  );

  hsps_timer u_rail (
    .clk_i  (clk_i),
    .rstn_i (rstn_i),
    .run_i  (cmp_i.rail_fast),
    .tc_i   (`HSPS_CW'(`HSPS_RAIL_CYC)),
    .done_o (rail_done)
  );

  // every supply, thermal and software condition that keeps the switch off
  assign fast_off    = vdd_done || rail_done;
  assign supplies_ok = !cmp_i.supply_high && !cmp_i.uv_low &&
                       !cmp_i.main_lockout && !fast_off && !therm_ff &&
                       !ctrl_ff[`HSPS_CTRL_SW_OFF];

  // breaker trips on timer high or internal delay expiry
  assign cb_trip = state_ff == HSPS_CB &&
                   (cmp_i.timer_tied ? cb_done : cmp_i.timer_high);

  // Sequencer; a supply drop restarts qualification from ON, or from CB unless the breaker trips
  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
      state_ff <= HSPS_QUAL;
    else
    begin
      case (state_ff)
        HSPS_QUAL:  if (qual_done)
                      state_ff <= HSPS_ON;
        HSPS_ON:    if (!supplies_ok)
                      state_ff <= HSPS_QUAL;
                    else if (cmp_i.overcurrent)
                      state_ff <= HSPS_CB;
        HSPS_CB:    if (cb_trip)
                      state_ff <= HSPS_DISCH;
                    else if (!supplies_ok)
                      state_ff <= HSPS_QUAL;
                    else if (!cmp_i.overcurrent)
                      state_ff <= HSPS_ON;
        // wait for timer discharge, then cool down
        HSPS_DISCH: if (cmp_i.timer_tied || cmp_i.timer_low)
                      state_ff <= HSPS_COOL;
        HSPS_COOL:  if (cool_done)
                      state_ff <= HSPS_LATCH;
        // held off until the latch is cleared
        HSPS_LATCH: if (!fault_ff)
                      state_ff <= supplies_ok ? HSPS_ON : HSPS_QUAL;
        default:    state_ff <= HSPS_QUAL;
      endcase
    end
  end

  // fault latch, the trip wins over a clear
  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
      fault_ff <= 1'b0;
    else if (cb_trip)
      fault_ff <= 1'b1;
    else if (cmp_i.uv_reset)
      fault_ff <= 1'b0;
  end

  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
      therm_ff <= 1'b0;
    else if (cmp_i.temp_hi)
      therm_ff <= 1'b1;
    else if (cmp_i.temp_lo)
      therm_ff <= 1'b0;
  end

  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
      pg_ok_ff <= 1'b0;
    else if (cmp_i.fb_pg_lo)
      pg_ok_ff <= 1'b0;
    else if (cmp_i.fb_pg_hi && cmp_i.gate_ovd)
      pg_ok_ff <= 1'b1;
  end

  // foldback request to the current limit amplifier
  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
      fold_ff <= 1'b0;
    else
      fold_ff <= cmp_i.fb_fold;
  end

  // Gate requests; the sequencer state lags by one cycle, so
  // turn-off causes are taken straight from the comparators
  // short-circuit, lockout or fast shutdown
  assign want_fast   = fast_off || cmp_i.main_lockout ||
                       (cmp_i.overcurrent && state_ff == HSPS_CB);
  // normal turn-off for every other off cause
  assign want_norm   = !supplies_ok || state_ff == HSPS_DISCH ||
                       state_ff == HSPS_COOL || state_ff == HSPS_LATCH ||
                       state_ff == HSPS_QUAL || cb_trip;
  assign want_charge = state_ff == HSPS_ON || state_ff == HSPS_CB;

  hsps_gate_sel u_gate (
    .clk_i         (clk_i),
    .rstn_i        (rstn_i),
    .want_fast_i   (want_fast),
    .want_norm_i   (want_norm),
    .want_charge_i (want_charge),
    .gate_o        (gate_o)
  );

  // Open-drain outputs: fault pulls low when latched, power good pulls low until good
  assign power_good_o    = 1'b0;
  assign power_good_oe_o = !pg_ok_ff;
  assign fault_o         = 1'b0;
  assign fault_oe_o      = fault_ff;
  assign foldback_o      = fold_ff;
  assign timer_up_o      = state_ff == HSPS_CB && !cmp_i.timer_tied;
  assign timer_dn_o      = state_ff == HSPS_DISCH;

  // Bus write channels taken in either order
  assign s_axi_awready = !aw_hold_ff && !s_axi_bvalid;
  assign s_axi_wready  = !w_hold_ff && !s_axi_bvalid;
  assign wr_go         = aw_hold_ff && w_hold_ff && !s_axi_bvalid;

  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
    begin
      aw_hold_ff <= 1'b0;
      w_hold_ff  <= 1'b0;
      awaddr_ff  <= 12'h000;
      wdata_ff   <= 32'h0000_0000;
      wstrb_ff   <= 4'h0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_hold_ff <= 1'b1;
        awaddr_ff  <= s_axi_awaddr;
      end
      else if (wr_go)
        aw_hold_ff <= 1'b0;
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_hold_ff <= 1'b1;
        wdata_ff  <= s_axi_wdata;
        wstrb_ff  <= s_axi_wstrb;
      end
      else if (wr_go)
        w_hold_ff <= 1'b0;
    end
  end

  // Write response; unmapped offsets answer with an error
  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `HSPS_RESP_OKAY;
    end
    else if (wr_go)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= is_mapped(awaddr_ff) ? `HSPS_RESP_OKAY
                                           : `HSPS_RESP_SLVERR;
    end
    else if (s_axi_bready)
      s_axi_bvalid <= 1'b0;
  end

  // Writable registers; a zero count is clamped to one cycle
  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
    begin
      ctrl_ff    <= `HSPS_CTRL_RST;
      qual_tc_ff <= QUAL_CYC;
      cb_tc_ff   <= CB_CYC;
      cool_tc_ff <= COOL_CYC;
    end
    else if (wr_go)
    begin
      case (awaddr_ff)
        `HSPS_OFS_CTRL:
          ctrl_ff <= merge_bytes(ctrl_ff, wdata_ff, wstrb_ff) &
                     32'h0000_0001;
        `HSPS_OFS_QUAL_TC:
          qual_tc_ff <= merge_tc(qual_tc_ff, wdata_ff, wstrb_ff);
        `HSPS_OFS_CB_TC:
          cb_tc_ff <= merge_tc(cb_tc_ff, wdata_ff, wstrb_ff);
        `HSPS_OFS_COOL_TC:
          cool_tc_ff <= merge_tc(cool_tc_ff, wdata_ff, wstrb_ff);
        default: ;
      endcase
    end
  end

  // Read channel, one cycle after the address is taken
  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= `HSPS_RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= is_mapped(s_axi_araddr) ? `HSPS_RESP_OKAY
                                              : `HSPS_RESP_SLVERR;
      case (s_axi_araddr)
        `HSPS_OFS_CTRL:    s_axi_rdata <= ctrl_ff;
        `HSPS_OFS_STATUS:  s_axi_rdata <= {19'h0_0000, fault_i, power_good_i,
                                           1'b0, fold_ff, therm_ff, fast_off,
                                           cmp_i.uv_low, cmp_i.supply_high,
                                           pg_ok_ff, fault_ff, state_ff};
        `HSPS_OFS_QUAL_TC: s_axi_rdata <= {8'h00, qual_tc_ff};
        `HSPS_OFS_CB_TC:   s_axi_rdata <= {8'h00, cb_tc_ff};
        `HSPS_OFS_COOL_TC: s_axi_rdata <= {8'h00, cool_tc_ff};
        default:           s_axi_rdata <= 32'h0000_0000;
      endcase
    end
    else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

  // Checks on the sequencer and pins
  default clocking cb_chk @(posedge clk_i); endclocking
  default disable iff (!rstn_i);

  sequence seq_trip;
    state_ff == HSPS_CB && cb_trip;
  endsequence

  sequence seq_latched;
    state_ff == HSPS_DISCH && fault_ff;
  endsequence

  a_pg_low_fb: assert property (cmp_i.fb_pg_lo |=> power_good_oe_o)
    else $error("power good not pulled low on low feedback");
  a_pg_release: assert property ($fell(power_good_oe_o) |->
      $past(cmp_i.fb_pg_hi && cmp_i.gate_ovd))
    else $error("power good released without both conditions");
  a_trip_latch: assert property (seq_trip |=>
      seq_latched ##0 fault_oe_o)
    else $error("breaker trip did not latch the fault");
  a_ov_off: assert property (cmp_i.supply_high |=> !gate_o.charge)
    else $error("gate still charging during overvoltage");
  a_uv_norm: assert property (cmp_i.uv_low && !want_fast |=>
      gate_o.pd_norm && !gate_o.charge)
    else $error("undervoltage did not select normal pull-down");
  a_uv_clear: assert property (cmp_i.uv_reset && !cb_trip |=> !fault_ff)
    else $error("fault latch not cleared by reset level");
  a_lockout_fast: assert property (cmp_i.main_lockout |=>
      gate_o.pd_fast && !gate_o.charge)
    else $error("lockout did not force fast pull-down");
  a_fast_prio: assert property (gate_o.pd_fast |->
      !gate_o.pd_norm && !gate_o.charge)
    else $error("fast pull-down shares the gate");
  a_latch_hold: assert property (state_ff == HSPS_LATCH && fault_ff |=>
      state_ff == HSPS_LATCH)
    else $error("left latch-off with fault set");
  a_qual_entry: assert property ($rose(state_ff == HSPS_ON) |->
      $past(qual_done || state_ff == HSPS_LATCH ||
            state_ff == HSPS_CB))
    else $error("switch on without qualification");
endmodule : hsps_top

`default_nettype wire

// File: hsps_env.sv
`timescale 1ns/1ps
`default_nettype none
// Supply, load and timer capacitor on the far side of the sequencer
module hsps_env (
  input  wire logic                 clk_i,
  input  wire logic [1:0]           uv_i,
  input  wire logic [6:0]           ev_i,
  input  wire logic                 up_i,
  input  wire logic                 dn_i,
  input  wire hsps_pkg::hsps_gate_t gate_i,
  input  wire logic                 pg_oe_i,
  input  wire logic                 flt_oe_i,
  output hsps_pkg::hsps_cmp_t       cmp_o,
  output logic                      pg_o,
  output logic                      flt_o
);
  import hsps_pkg::*;
  logic [1:0] lv;
  logic       on_ff = 1'b0;
  int         tn_ff = 0;
  // Pull-ups win when nobody sinks the line
  assign pg_o  = !pg_oe_i;
  assign flt_o = !flt_oe_i;
  // divider pulled down, or fault pin tied to it
  assign lv = (ev_i[3] && !flt_o) ? 2'h0 : uv_i;
  // Output follows the gate a cycle late; node charges and bleeds
  always_ff @(posedge clk_i)
  begin
    on_ff <= gate_i.charge;
    tn_ff <= up_i ? tn_ff + 1 : (dn_i && tn_ff > 0) ? tn_ff - 1 : tn_ff;
  end
  // Comparator levels; lockout drives the supply deep enough for both
  assign cmp_o = '{!on_ff, on_ff, on_ff, ev_i[4], ev_i[0], lv != 2'h2,
                   lv == 2'h0, ev_i[2], tn_ff >= 4, tn_ff == 0, ev_i[5],
                   ev_i[1], ev_i[1], 1'b0, ev_i[6], !ev_i[6]};
endmodule : hsps_env
`default_nettype wire

// File: tb_hsps_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_hsps_top;
  import hsps_pkg::*;
  localparam logic [23:0] QC = 24'h00_0014;
  localparam logic [23:0] CC = 24'h00_0014;
  localparam logic [23:0] BC = 24'h00_000a;
  logic        clk_i, rstn_i, power_good_i, fault_i, foldback_o;
  logic        timer_up_o, timer_dn_o, power_good_oe_o, fault_oe_o;
  hsps_cmp_t   cmp_i;
  hsps_gate_t  gate_o;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [31:0] tc [5];
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, uv;
  logic [6:0]  ev;
  logic [15:0] lf;
  int          error_cnt, cmp_count, cyc, n;

  hsps_top #(.QUAL_CYC(QC), .COOL_CYC(CC), .CB_CYC(BC)) hsps_top_i (
    .clk_i, .rstn_i, .cmp_i, .gate_o, .foldback_o, .timer_up_o, .timer_dn_o,
    .power_good_i, .power_good_o(), .power_good_oe_o, .fault_i, .fault_o(),
    .fault_oe_o, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr,
    .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid,
    .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready,
    .s_axi_rdata, .s_axi_rresp);
  hsps_env hsps_env_i (.clk_i, .uv_i(uv), .ev_i(ev), .up_i(timer_up_o),
    .dn_i(timer_dn_o), .gate_i(gate_o), .pg_oe_i(power_good_oe_o),
    .flt_oe_i(fault_oe_o), .cmp_o(cmp_i), .pg_o(power_good_i),
    .flt_o(fault_i));

  // Free-running 100 MHz clock
  initial
  begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  // Hang guard, far above the whole run
  always @(posedge clk_i)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      error_cnt++;
      wrap_up();
    end
  end

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : wrap_up

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e)
    begin
      error_cnt++;
      $display("ERROR at %0t seen %h expected %h", $time, s, e);
    end
  endtask : chk

  function automatic logic [15:0] nx(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction : nx

  // One access; handshakes judged mid-cycle so edge races cannot bite
  task automatic xf(input bit w, input logic [11:0] a,
                    input logic [31:0] d, input logic [1:0] r);
    bit ta, tw, tr, td;
    logic [1:0] rs;
    td = 1'b0;
    // Let the previous transfer's release take effect first
    @(posedge clk_i);
    s_axi_awaddr  <= a;
    s_axi_araddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= w;
    s_axi_wvalid  <= w;
    s_axi_arvalid <= !w;
    s_axi_bready  <= w;
    s_axi_rready  <= !w;
    while (!td)
    begin
      @(negedge clk_i);
      ta = s_axi_awvalid && s_axi_awready;
      tw = s_axi_wvalid && s_axi_wready;
      tr = s_axi_arvalid && s_axi_arready;
      td = w ? s_axi_bvalid : s_axi_rvalid;
      rs = w ? s_axi_bresp : s_axi_rresp;
      rd = s_axi_rdata;
      @(posedge clk_i);
      s_axi_awvalid <= s_axi_awvalid && !ta;
      s_axi_wvalid  <= s_axi_wvalid && !tw;
      s_axi_arvalid <= s_axi_arvalid && !tr;
    end
    s_axi_bready <= 1'b0;
    s_axi_rready <= 1'b0;
    chk(rs, r);
  endtask : xf

  task automatic upto(input bit f, output int k);
    k = 0;
    while (!(f ? fault_i === 1'b0 : gate_o.charge === 1'b1) && k < 300)
    begin
      @(posedge clk_i);
      k++;
    end
  endtask : upto

  task automatic back_on();
    upto(1'b0, n);
    chk(n < 300, 1'b1);
  endtask : back_on

  // Main sequence
  initial
  begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, s_axi_awaddr} = '0;
    {s_axi_bready, s_axi_rready, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hf;
    {uv, ev, rstn_i, error_cnt, cmp_count, cyc} = {2'h1, 7'h00, 1'b0, 96'h0};
    lf = 16'h9556;
    // Status after reset: fault pin high, undervoltage flagged
    tc = '{32'h0, 32'h0000_1040, {8'h00, QC}, {8'h00, BC}, {8'h00, CC}};
    repeat (16) @(posedge clk_i);
    rstn_i <= 1'b1;
    chk({gate_o, fault_i, power_good_i}, 5'h0a);
    for (int i = 0; i < 5; i++)
    begin
      xf(1'b0, 12'(4 * i), 32'h0, 2'h0);
      chk(rd, tc[i]);
    end
    for (int i = 2; i < 5; i++)
    begin
      lf = nx(lf);
      xf(1'b1, 12'(4 * i), {lf, lf}, 2'h0);
      xf(1'b0, 12'(4 * i), 32'h0, 2'h0);
      chk(rd, {8'h00, lf[7:0], lf} | 32'h1);
      xf(1'b1, 12'(4 * i), tc[i], 2'h0);
    end
    xf(1'b0, 12'h100, 32'h0, 2'h2);
    chk(rd, 32'h0);
    xf(1'b1, 12'h100, 32'hffff_ffff, 2'h2);
    $display("registers done");
    uv <= 2'h2;
    repeat (10) @(posedge clk_i);
    uv <= 2'h1;
    repeat (2) @(posedge clk_i);
    uv <= 2'h2;
    upto(1'b0, n);
    chk(n >= QC && n <= QC + 4, 1'b1);
    chk(gate_o, 3'h4);
    repeat (5) @(posedge clk_i);
    chk(power_good_i, 1'b1);
    ev <= 7'h01;
    repeat (5) @(posedge clk_i);
    chk({gate_o, power_good_i}, 4'h4);
    ev <= 7'h00;
    back_on();
    uv <= 2'h1;
    repeat (5) @(posedge clk_i);
    chk(gate_o, 3'h2);
    uv <= 2'h2;
    back_on();
    ev <= 7'h02;
    repeat (5) @(posedge clk_i);
    chk(gate_o, 3'h1);
    // Supply held low well past the fast shutdown filter
    repeat (600) @(posedge clk_i);
    xf(1'b0, 12'h004, 32'h0, 2'h0);
    chk(rd[7], 1'b1);
    ev <= 7'h00;
    back_on();
    ev <= 7'h40;
    repeat (5) @(posedge clk_i);
    chk(gate_o.charge, 1'b0);
    ev <= 7'h10;
    back_on();
    repeat (3) @(posedge clk_i);
    chk(foldback_o, 1'b1);
    // Software off; a write without byte 0 must not undo it
    xf(1'b1, 12'h000, 32'h1, 2'h0);
    s_axi_wstrb <= 4'he;
    xf(1'b1, 12'h000, 32'h0, 2'h0);
    xf(1'b0, 12'h000, 32'h0, 2'h0);
    chk({rd[3:0], gate_o}, 7'h0a);
    s_axi_wstrb <= 4'hf;
    xf(1'b1, 12'h000, 32'h0, 2'h0);
    back_on();
    $display("supply faults done");
    ev <= 7'h04;
    repeat (3) @(posedge clk_i);
    chk({gate_o, timer_up_o}, 4'h3);
    upto(1'b1, n);
    chk({n < 300, timer_dn_o}, 2'h3);
    ev <= 7'h00;
    repeat (60) @(posedge clk_i);
    xf(1'b0, 12'h004, 32'h0, 2'h0);
    chk({rd[3:0], gate_o.charge, fault_i}, 6'h34);
    // divider held low for a full microsecond
    uv <= 2'h0;
    repeat (100) @(posedge clk_i);
    chk(fault_i, 1'b1);
    uv <= 2'h2;
    back_on();
    ev <= 7'h24;
    upto(1'b1, n);
    chk(n >= BC && n <= BC + 5, 1'b1);
    {ev, uv} <= {7'h00, 2'h0};
    repeat (100) @(posedge clk_i);
    uv <= 2'h2;
    back_on();
    // automatic retry with the fault pin tied to the divider, capacitor timing
    ev <= 7'h0c;
    upto(1'b1, n);
    ev <= 7'h08;
    back_on();
    $display("breaker done");
    wrap_up();
  end
endmodule : tb_hsps_top
`default_nettype wire
